/* File: core/tnc_event_sync.sv */
// Sticky event register with mask and level interrupt output.
// Assumes event pulses are synchronous to clk_i.
`default_nettype none

module tnc_event_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Events and software access
  input wire logic [WIDTH-1:0] evt_i,
  input wire logic [WIDTH-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [WIDTH-1:0] mask_i,
  // State out
  output logic [WIDTH-1:0] stat_o,
  output logic [WIDTH-1:0] mask_o,
  output logic irq_o
);
  // Elaboration check: clear and mask paths are sized for at most one bus word
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_bad
    $error("tnc_event_sync: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stat;
    logic [WIDTH-1:0] mask;
  } tnc_evt_state_t;

  tnc_evt_state_t st_reg, st_next;

  // Per bit: a new event wins over a clear in the same cycle
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < WIDTH; i++) begin
      st_next.stat[i] = evt_i[i] | (st_reg.stat[i] & ~clr_i[i]);
    end
    if (mask_we_i) begin
      st_next.mask = mask_i;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign stat_o = st_reg.stat;
  assign mask_o = st_reg.mask;
  assign irq_o = |(st_reg.stat & st_reg.mask);
endmodule // tnc_event_sync

`default_nettype wire

/* File: core/tnc_pkg.sv */
// Types shared by the trap and nesting control block.
// Assumes the constants header is included where offsets are needed.
`default_nettype none

package tnc_pkg;
  // Trap causes reported by the arithmetic, DMA and system units
  typedef enum logic [3:0] {
    TNC_C_NONE,
    TNC_C_OVA,
    TNC_C_OVB,
    TNC_C_COVA,
    TNC_C_COVB,
    TNC_C_SHIFT,
    TNC_C_DIV0,
    TNC_C_MATH,
    TNC_C_DMAC,
    TNC_C_ADDR,
    TNC_C_STACK,
    TNC_C_OSC
  } tnc_cause_t;

  // Bus slave phase
  typedef enum logic [0:0] {
    TNC_S_IDLE,
    TNC_S_DONE
  } tnc_bus_state_t;
endpackage : tnc_pkg

`default_nettype wire

/* File: core/tnc_regs.svh */
// Trap and nesting control block: offsets, bit positions, reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses decoded on all four address bits.
`ifndef TNC_REGS_SVH
`define TNC_REGS_SVH

// Byte offsets of the registers
`define TNC_OFF_CTRL 4'h0
`define TNC_OFF_EVT 4'h4
`define TNC_OFF_MASK 4'h8
`define TNC_OFF_PREEMPT 4'hC

// Bit positions inside the trap and nesting control register
`define TNC_B_NEST_DIS 15
`define TNC_B_OVA 14
`define TNC_B_OVB 13
`define TNC_B_COVA 12
`define TNC_B_COVB 11
`define TNC_B_OVA_TE 10
`define TNC_B_OVB_TE 9
`define TNC_B_COV_TE 8
`define TNC_B_SHIFT 7
`define TNC_B_DIV0 6
`define TNC_B_DMAC 5
`define TNC_B_MATH 4
`define TNC_B_ADDR 3
`define TNC_B_STACK 2
`define TNC_B_OSC 1

// Software-writable bits, all but the hardware-cleared divide bit and bit 0
`define TNC_WR_MASK 16'hFFBE
`define TNC_CTRL_RST 16'h0000
`define TNC_EVT_RST 8'h00
`define TNC_MASK_RST 8'h00

`endif

/* File: core/tnc_trap_ctrl.sv */
// Trap status and nesting control register with Avalon-MM slave access.
// Assumes trap causes arrive as one-cycle pulses synchronous to clk_i,
// and that the core's arithmetic units report raw overflow conditions.
`default_nettype none
`include "tnc_regs.svh"

module tnc_trap_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Raw arithmetic conditions from the core
  input wire logic acc_a_ovf_i,
  input wire logic acc_b_ovf_i,
  input wire logic acc_a_cat_i,
  input wire logic acc_b_cat_i,
  // Other trap causes, one-cycle pulses
  input wire logic shift_err_i,
  input wire logic div0_err_i,
  input wire logic dmac_err_i,
  input wire logic addr_err_i,
  input wire logic stack_err_i,
  input wire logic osc_fail_i,
  // Hardware clear of the divide-by-zero status
  input wire logic div0_hw_clr_i,
  // Interrupt nesting with the core's interrupt controller
  input wire logic irq_active_i,
  input wire logic irq_request_i,
  output logic preempt_allow_o,
  output logic nesting_disable_o,
  // Trap request to the core and event interrupt
  output logic trap_o,
  output logic irq_o
);
  // Event index in the sticky status register
  localparam int EV_OVF = 0;
  localparam int EV_COV = 1;
  localparam int EV_MATH = 2;
  localparam int EV_DMAC = 3;
  localparam int EV_SYS = 4;
  localparam int EV_BLOCK = 5;
  localparam int EVN = 8;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] rdata;
    logic [1:0] resp;
    tnc_pkg::tnc_bus_state_t bus;
    logic trap;
  } tnc_state_t;

  tnc_state_t st_reg, st_next;

  logic ova_trap, ovb_trap, cova_trap, covb_trap, math_trap, any_trap;
  logic sel_ctrl, sel_evt, sel_mask, sel_pre, mapped;
  logic wr_go, rd_go;
  logic [15:0] sw_val, hw_set;
  logic [EVN-1:0] evt, evt_clr, evt_stat, evt_mask;
  logic nest_block;

  // Trap qualification: overflow and catastrophic causes gated by their enable bits, the others pass ungated
  assign ova_trap = acc_a_ovf_i & st_reg.ctrl[`TNC_B_OVA_TE];
  assign ovb_trap = acc_b_ovf_i & st_reg.ctrl[`TNC_B_OVB_TE];
  assign cova_trap = acc_a_cat_i & st_reg.ctrl[`TNC_B_COV_TE];
  assign covb_trap = acc_b_cat_i & st_reg.ctrl[`TNC_B_COV_TE];
  assign math_trap = shift_err_i | div0_err_i;
  assign any_trap = ova_trap | ovb_trap | cova_trap | covb_trap | math_trap
                    | dmac_err_i | addr_err_i | stack_err_i | osc_fail_i;

  // Flags set by the cause of each trap taken
  always_comb begin
    hw_set = 16'h0000;
    hw_set[`TNC_B_OVA] = ova_trap;
    hw_set[`TNC_B_OVB] = ovb_trap;
    hw_set[`TNC_B_COVA] = cova_trap;
    hw_set[`TNC_B_COVB] = covb_trap;
    hw_set[`TNC_B_SHIFT] = shift_err_i;
    hw_set[`TNC_B_DIV0] = div0_err_i;
    hw_set[`TNC_B_DMAC] = dmac_err_i;
    hw_set[`TNC_B_MATH] = math_trap;
    hw_set[`TNC_B_ADDR] = addr_err_i;
    hw_set[`TNC_B_STACK] = stack_err_i;
    hw_set[`TNC_B_OSC] = osc_fail_i;
  end

  // Nesting: a request may preempt only while nesting is enabled
  assign nesting_disable_o = st_reg.ctrl[`TNC_B_NEST_DIS];
  assign preempt_allow_o = ~st_reg.ctrl[`TNC_B_NEST_DIS];
  assign nest_block = irq_active_i & irq_request_i & st_reg.ctrl[`TNC_B_NEST_DIS];

  // Address decode
  always_comb begin
    sel_ctrl = 1'b0;
    sel_evt = 1'b0;
    sel_mask = 1'b0;
    sel_pre = 1'b0;
    if (address == `TNC_OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (address == `TNC_OFF_EVT) begin
      sel_evt = 1'b1;
    end else if (address == `TNC_OFF_MASK) begin
      sel_mask = 1'b1;
    end else if (address == `TNC_OFF_PREEMPT) begin
      sel_pre = 1'b1;
    end
  end
  assign mapped = sel_ctrl | sel_evt | sel_mask | sel_pre;

  // One-cycle wait: request taken in idle, answered in done phase
  assign wr_go = write & (st_reg.bus == tnc_pkg::TNC_S_IDLE);
  assign rd_go = read & ~write & (st_reg.bus == tnc_pkg::TNC_S_IDLE);
  assign waitrequest = (read | write) & (st_reg.bus == tnc_pkg::TNC_S_IDLE);

  // Byte lanes 0 and 1 merge for the control register
  always_comb begin
    sw_val = st_reg.ctrl;
    if (byteenable[0]) begin
      sw_val[7:0] = writedata[7:0];
    end
    if (byteenable[1]) begin
      sw_val[15:8] = writedata[15:8];
    end
  end

  // Event sources: overflow, catastrophic, math, DMA, system, blocked preempt
  always_comb begin
    evt = '0;
    evt[EV_OVF] = ova_trap | ovb_trap;
    evt[EV_COV] = cova_trap | covb_trap;
    evt[EV_MATH] = math_trap;
    evt[EV_DMAC] = dmac_err_i;
    evt[EV_SYS] = addr_err_i | stack_err_i | osc_fail_i;
    evt[EV_BLOCK] = nest_block;
    evt_clr = '0;
    if (wr_go && sel_evt && byteenable[0]) begin
      evt_clr = writedata[EVN-1:0];
    end
  end

  tnc_event_sync #(
    .WIDTH(EVN)
  ) u_evt (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .evt_i(evt),
    .clr_i(evt_clr),
    .mask_we_i(wr_go & sel_mask & byteenable[0]),
    .mask_i(writedata[EVN-1:0]),
    .stat_o(evt_stat),
    .mask_o(evt_mask),
    .irq_o(irq_o)
  );

  // Register and bus next state
  always_comb begin
    st_next = st_reg;
    st_next.trap = any_trap;
    // Software write: writable bits take the new value, flags may be written to zero
    if (wr_go && sel_ctrl) begin
      st_next.ctrl = (sw_val & `TNC_WR_MASK) | (st_reg.ctrl & ~`TNC_WR_MASK);
    end
    // Hardware clear of the read-only divide status
    if (div0_hw_clr_i) begin
      st_next.ctrl[`TNC_B_DIV0] = 1'b0;
    end
    // Hardware set wins over software clear in the same cycle
    st_next.ctrl = st_next.ctrl | hw_set;
    st_next.ctrl[0] = 1'b0;
    case (st_reg.bus)
      tnc_pkg::TNC_S_IDLE: begin
        if (wr_go || rd_go) begin
          st_next.bus = tnc_pkg::TNC_S_DONE;
          st_next.resp = mapped ? 2'h0 : 2'h2;
          st_next.rdata = 32'h0000_0000;
          if (rd_go) begin
            if (sel_ctrl) begin
              st_next.rdata = {16'h0000, st_reg.ctrl};
            end else if (sel_evt) begin
              st_next.rdata = {24'h00_0000, evt_stat};
            end else if (sel_mask) begin
              st_next.rdata = {24'h00_0000, evt_mask};
            end else if (sel_pre) begin
              st_next.rdata = {30'h0000_0000, irq_active_i, preempt_allow_o};
            end
          end
        end
      end
      tnc_pkg::TNC_S_DONE: begin
        st_next.bus = tnc_pkg::TNC_S_IDLE;
      end
      default: begin
        st_next.bus = tnc_pkg::TNC_S_IDLE;
      end
    endcase
  end

  // State register; all control bits clear on reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{ctrl: `TNC_CTRL_RST, rdata: 32'h0000_0000, resp: 2'h0,
                  bus: tnc_pkg::TNC_S_IDLE, trap: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign readdata = st_reg.rdata;
  assign response = st_reg.resp;
  assign trap_o = st_reg.trap;
endmodule // tnc_trap_ctrl

`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the trap and nesting control block.
// Assumes package, design, core model and checker are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, q;
  logic waitrequest, preempt_allow_o, nesting_disable_o, trap_o, irq_o;
  logic [1:0] response;
  logic div0_hw_clr_i = 1'b0;
  logic irq_active_i = 1'b0;
  logic irq_request_i = 1'b0;
  logic [3:0] byteenable = 4'hF;
  tnc_pkg::tnc_cause_t cause = tnc_pkg::TNC_C_NONE;
  logic [11:0] pulse;
  int mismatches = 0;
  int checked = 0;
  // Flags each cause code sets; cause 7 has no line of its own
  logic [15:0] exp_tab [12] = '{16'h0000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
    16'h0090, 16'h0050, 16'h0000, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // Core model and design under test
  tnc_core_model u_core (.cause_i(cause), .pulse_o(pulse));
  tnc_trap_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .acc_a_ovf_i(pulse[1]),
    .acc_b_ovf_i(pulse[2]), .acc_a_cat_i(pulse[3]), .acc_b_cat_i(pulse[4]),
    .shift_err_i(pulse[5]), .div0_err_i(pulse[6]), .dmac_err_i(pulse[8]),
    .addr_err_i(pulse[9]), .stack_err_i(pulse[10]), .osc_fail_i(pulse[11]),
    .div0_hw_clr_i(div0_hw_clr_i), .irq_active_i(irq_active_i),
    .irq_request_i(irq_request_i),
    .preempt_allow_o(preempt_allow_o), .nesting_disable_o(nesting_disable_o),
    .trap_o(trap_o), .irq_o(irq_o));
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One access, held until waitrequest is seen low; a hang ends the run
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Looked at right after the edge, so the values seen are those the slave had at it
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      $display("[ERR] %0t bus access timed out", $time);
      report_and_stop();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // One idle edge, so the next call never re-raises a strobe in this time step
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // One-cycle cause, trap_o looked at in the following cycle
  task automatic fire(input int c, input logic t);
    cause <= tnc_pkg::tnc_cause_t'(c);
    @(posedge clk_i);
    cause <= tnc_pkg::TNC_C_NONE;
    @(negedge clk_i);
    chk(32'(trap_o), 32'(t));
    @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    // Reset values, then the read-only and unused bits
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0000_0000);
    acc(1'b1, 4'h0, 32'h0000_FFFF);
    rd(4'h0, 32'h0000_FFBE);
    irq_active_i <= 1'b1;
    rd(4'hC, 32'h0000_0002);
    acc(1'b1, 4'h0, 32'h0000_0700);
    rd(4'hC, 32'h0000_0003);
    irq_active_i <= 1'b0;
    // Each cause with enables on; divide flag survives software clears
    for (int c = 1; c < 12; c++) begin
      if (c == 7) continue;
      fire(c, 1'b1);
      rd(4'h0, {16'h0000, exp_tab[c] | 16'h0700 | (c > 6 ? 16'h0040 : 16'h0000)});
      acc(1'b1, 4'h0, 32'h0000_0700);
    end
    div0_hw_clr_i <= 1'b1;
    @(posedge clk_i);
    div0_hw_clr_i <= 1'b0;
    rd(4'h0, 32'h0000_0700);
    // Overflows with enables off raise nothing
    acc(1'b1, 4'h0, 32'h0000_0000);
    for (int c = 1; c < 5; c++) fire(c, 1'b0);
    rd(4'h0, 32'h0000_0000);
    // Sticky events: masked, unmasked, cleared by writing ones
    rd(4'h4, 32'h0000_001F);
    chk(32'(irq_o), 32'h0000_0000);
    acc(1'b1, 4'h8, 32'h0000_0004);
    chk(32'(irq_o), 32'h0000_0001);
    acc(1'b1, 4'h4, 32'h0000_0004);
    chk(32'(irq_o), 32'h0000_0000);
    acc(1'b1, 4'h4, 32'h0000_00FF);
    rd(4'h4, 32'h0000_0000);
    // Unmapped place: write ignored, read zero with slave error
    acc(1'b1, 4'h2, 32'h0000_FFFF);
    rd(4'h2, 32'h0000_0000);
    chk(32'(response), 32'h0000_0002);
    // A request that meets an active interrupt is blocked only while nesting is off
    acc(1'b1, 4'h0, 32'h0000_8000);
    irq_active_i <= 1'b1;
    irq_request_i <= 1'b1;
    @(posedge clk_i);
    irq_request_i <= 1'b0;
    rd(4'h4, 32'h0000_0020);
    // Lane 0 alone leaves the nesting bit where it was
    byteenable <= 4'h1;
    acc(1'b1, 4'h0, 32'h0000_00FF);
    byteenable <= 4'hF;
    rd(4'h0, 32'h0000_80BE);
    acc(1'b1, 4'h4, 32'h0000_0020);
    acc(1'b1, 4'h0, 32'h0000_0000);
    irq_request_i <= 1'b1;
    @(posedge clk_i);
    irq_request_i <= 1'b0;
    irq_active_i <= 1'b0;
    rd(4'h4, 32'h0000_0000);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

/* File: dv/tnc_core_model.sv */
// Stand-in for the core units that raise trap causes.
// Assumes the bench holds a cause code for exactly one cycle.
`default_nettype none
module tnc_core_model (
  // Cause chosen by the bench
  input wire tnc_pkg::tnc_cause_t cause_i,
  // One line per cause code
  output logic [11:0] pulse_o
);
  // Combinational decode, so a pulse lasts as long as the code
  assign pulse_o = 12'h001 << cause_i;
endmodule // tnc_core_model
`default_nettype wire

/* File: dv/tnc_trap_monitor.sv */
// Assertion checker for the trap and nesting control block.
// Assumes it is bound to tnc_trap_ctrl and sees only its ports.
`default_nettype none
module tnc_trap_monitor (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Trap causes
  input wire logic acc_a_ovf_i,
  input wire logic acc_b_ovf_i,
  input wire logic acc_a_cat_i,
  input wire logic acc_b_cat_i,
  input wire logic shift_err_i,
  input wire logic div0_err_i,
  input wire logic dmac_err_i,
  input wire logic addr_err_i,
  input wire logic stack_err_i,
  input wire logic osc_fail_i,
  // Outputs to the core
  input wire logic preempt_allow_o,
  input wire logic nesting_disable_o,
  input wire logic trap_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Any cause at all, so a trap can be traced back to one
  logic any_cause;
  assign any_cause = acc_a_ovf_i | acc_b_ovf_i | acc_a_cat_i | acc_b_cat_i | shift_err_i
    | div0_err_i | dmac_err_i | addr_err_i | stack_err_i | osc_fail_i;
  // Bus phases: request taken, then the answering read or write cycle
  sequence s_taken; (read || write) && waitrequest; endsequence
  sequence s_rdone; read && !waitrequest; endsequence
  sequence s_wdone; write && !waitrequest; endsequence
  a_bus_one_wait: assert property (s_taken |=> !waitrequest)
    else $error("wait not one cycle");
  // The write lands at the edge that ends the wait cycle, so the new bit shows while it retires
  a_preempt_rule: assert property (s_wdone ##0 (address == 4'h0 && byteenable[1]) |->
    nesting_disable_o == writedata[15] && preempt_allow_o == !writedata[15])
    else $error("preempt allow wrong");
  a_math_trap: assert property ((shift_err_i || div0_err_i) |=> trap_o)
    else $error("math trap missing");
  a_dmac_trap: assert property (dmac_err_i |=> trap_o)
    else $error("dma trap missing");
  a_sys_trap: assert property ((addr_err_i || stack_err_i || osc_fail_i) |=> trap_o)
    else $error("system trap missing");
  a_trap_cause: assert property (trap_o |-> $past(any_cause))
    else $error("trap without cause");
  a_ctrl_low_zero: assert property (s_rdone ##0 address == 4'h0 |->
    readdata[0] == 1'b0 && readdata[31:16] == 16'h0000) else $error("unused bits set");
  a_unmapped_err: assert property (s_rdone ##0 address[1:0] != 2'b00 |->
    response == 2'b10) else $error("unmapped not refused");
endmodule // tnc_trap_monitor

bind tnc_trap_ctrl tnc_trap_monitor u_mon (.clk_i, .nrst_i, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .response, .acc_a_ovf_i, .acc_b_ovf_i,
  .acc_a_cat_i,
  .acc_b_cat_i, .shift_err_i, .div0_err_i, .dmac_err_i, .addr_err_i, .stack_err_i,
  .osc_fail_i, .preempt_allow_o, .nesting_disable_o, .trap_o);
`default_nettype wire
